// ### core/io_element_ddr.sv
// I/O element with single and double rate registers behind an AXI4-Lite slave
`timescale 1ns/1ps
`include "ioe_regs.svh"

module io_element_ddr
   import io_element_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [`N_IOCLK-1:0] io_clk,
   input wire blk_ctrl_s blk,
   input wire col_lines_s col,
   input wire logic dqs_pin_in,
   input wire logic pin_i,
   output logic pin_o,
   output logic pin_oe,
   output logic rx_hi,
   output logic rx_lo,
   output logic rx_route,
   input wire logic [`AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   // ************************************************
   // Declarations
   // ************************************************
   ctrl_s ctrl_ff;
   logic [31:0] sel0_ff, sel1_ff;
   logic load_ff;
   logic [`EXT_W-1:0] s1_ff, s2_ff, s3_ff, flt_ff;
   logic [31:0] pool;
   sel_t sel [`N_CTL];
   logic [`N_CTL-1:0] ctl;
   logic [2:0] lane;
   logic cki_q_ff, cko_q_ff, rise_d_ff, fall_d_ff;
   logic rise_in, fall_in, rise_out, fall_out;
   logic din_a, din_b, pin_v, oe_src, ini, aclr, ddr_in, ddr_out;
   logic in_pos_ff, in_neg_ff, lat_ff, out_a_ff, out_b_ff, oe_ff, oe_neg_ff;
   logic pin_o_ff, pin_oe_ff, rx_hi_ff, rx_lo_ff, rx_route_ff;
   logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
   logic aw_hold_ff, w_hold_ff;
   logic [1:0] bresp_ff, rresp_ff;
   logic [31:0] wdata_ff, rdata_ff;
   logic [3:0] wstrb_ff;
   logic [`AXI_AW-1:0] awaddr_ff;
   logic we;
   stat_s stat;

   // Byte-lane merge of a write into a stored word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = d[b*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   // ************************************************
   // Pin and dedicated clock synchronisers
   // ************************************************
   // Three stages; a change counts once stages two and three agree
   always_ff @(posedge mclk) begin
      if (rst) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
         flt_ff <= '0;
      end else begin
         s1_ff <= {pin_i, dqs_pin_in, io_clk};
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         flt_ff <= (s3_ff & ~(s2_ff ^ s3_ff)) | (flt_ff & (s2_ff ^ s3_ff));
      end
   end

   // ************************************************
   // Control source selection
   // ************************************************
   // Lanes beyond the column width fall back to lane zero
   assign lane = (ctrl_ff.lane < 3'(`COL_N)) ? ctrl_ff.lane : 3'h0;

   // Source pool: I/O clocks, block controls, column lane controls, strobe, constants
   assign pool[`N_IOCLK-1:0] = flt_ff[`N_IOCLK-1:0];
   assign pool[11:8] = blk.oe;
   assign pool[15:12] = blk.ce;
   assign pool[19:16] = blk.clk;
   assign pool[23:20] = blk.clr;
   assign pool[24] = col.oe[lane];
   assign pool[25] = col.ce_in[lane];
   assign pool[26] = col.ce_out[lane];
   assign pool[27] = col.clk[lane];
   assign pool[28] = col.clr[lane];
   assign pool[`SRC_DQS] = flt_ff[`N_IOCLK] & ctrl_ff.dqs_pin;
   assign pool[30] = 1'b0;
   assign pool[31] = 1'b1;

   // One selector and optional inversion per control
   for (genvar i = 0; i < `N_CTL; i++) begin : g_ctl
      if (i < `SEL_PER_REG) begin : g_lo
         assign sel[i] = sel0_ff[i*`SEL_W +: `SEL_W];
      end else begin : g_hi
         assign sel[i] = sel1_ff[(i-`SEL_PER_REG)*`SEL_W +: `SEL_W];
      end
      assign ctl[i] = pool[sel[i]] ^ ctrl_ff.inv[i];
   end

   // Data inputs, each with its own inversion
   assign din_a = col.data_a[lane] ^ ctrl_ff.inv[`INV_DA];
   assign din_b = col.data_b[lane] ^ ctrl_ff.inv[`INV_DB];
   assign pin_v = flt_ff[`N_IOCLK+1] ^ ctrl_ff.inv[`INV_PIN];
   assign oe_src = ctl[`CTL_OE] ^ ctrl_ff.oe_low;
   assign ini = ctrl_ff.preset;
   assign aclr = ctl[`CTL_ACLR];
   assign ddr_in = (ctrl_ff.mode == MODE_DDR_IN) || (ctrl_ff.mode == MODE_DDR_BIDIR);
   assign ddr_out = (ctrl_ff.mode == MODE_DDR_OUT) || (ctrl_ff.mode == MODE_DDR_BIDIR);

   // ************************************************
   // Element clock edges
   // ************************************************
   assign rise_in = ctl[`CTL_CKI] & ~cki_q_ff;
   assign fall_in = ~ctl[`CTL_CKI] & cki_q_ff;
   assign rise_out = ctl[`CTL_CKO] & ~cko_q_ff;
   assign fall_out = ~ctl[`CTL_CKO] & cko_q_ff;

   // Previous clock levels and delayed edge marks
   always_ff @(posedge mclk) begin
      if (rst) begin
         cki_q_ff <= 1'b0;
         cko_q_ff <= 1'b0;
         rise_d_ff <= 1'b0;
         fall_d_ff <= 1'b0;
      end else begin
         cki_q_ff <= ctl[`CTL_CKI];
         cko_q_ff <= ctl[`CTL_CKO];
         rise_d_ff <= rise_in;
         fall_d_ff <= fall_in;
      end
   end

   // ************************************************
   // Element registers
   // ************************************************
   // Input registers on their own clock and enable; clear or preset wins
   always_ff @(posedge mclk) begin
      if (rst) begin
         in_pos_ff <= 1'b0;
         in_neg_ff <= 1'b0;
      end else if (aclr || load_ff) begin
         in_pos_ff <= ini;
         in_neg_ff <= ini;
      end else begin
         if (rise_in && ctl[`CTL_CEI]) begin
            in_pos_ff <= ctl[`CTL_SCLR] ? ini : pin_v;
         end
         if (fall_in && ctl[`CTL_CEI] && ddr_in) begin
            in_neg_ff <= ctl[`CTL_SCLR] ? ini : pin_v;
         end
      end
   end

   // Latch, open while the input clock is high, only on data-group pins in DDR input modes
   always_ff @(posedge mclk) begin
      if (rst) begin
         lat_ff <= 1'b0;
      end else if (aclr || load_ff) begin
         lat_ff <= ini;
      end else if (ctrl_ff.dq_pin && ddr_in && ctl[`CTL_CKI]) begin
         lat_ff <= in_pos_ff;
      end
   end

   // Captured pair presented together after the falling edge in DDR input modes, after the rising edge otherwise
   always_ff @(posedge mclk) begin
      if (rst) begin
         rx_hi_ff <= 1'b0;
         rx_lo_ff <= 1'b0;
      end else if (ddr_in && fall_d_ff) begin
         rx_hi_ff <= ctrl_ff.dq_pin ? lat_ff : in_pos_ff;
         rx_lo_ff <= in_neg_ff;
      end else if (!ddr_in && rise_d_ff) begin
         rx_hi_ff <= in_pos_ff;
         rx_lo_ff <= in_pos_ff;
      end
   end

   // Pin level routed straight back to the array
   always_ff @(posedge mclk) begin
      if (rst) begin
         rx_route_ff <= 1'b0;
      end else begin
         rx_route_ff <= pin_v;
      end
   end

   // Output and enable registers on the shared output clock and enable
   always_ff @(posedge mclk) begin
      if (rst) begin
         out_a_ff <= 1'b0;
         out_b_ff <= 1'b0;
         oe_ff <= 1'b0;
      end else if (aclr || load_ff) begin
         out_a_ff <= ini;
         out_b_ff <= ini;
         oe_ff <= ini;
      end else if (rise_out && ctl[`CTL_CEO]) begin
         out_a_ff <= ctl[`CTL_SCLR] ? ini : din_a;
         out_b_ff <= ctl[`CTL_SCLR] ? ini : din_b;
         oe_ff <= ctl[`CTL_SCLR] ? ini : oe_src;
      end
   end

   // Falling-edge enable register
   always_ff @(posedge mclk) begin
      if (rst) begin
         oe_neg_ff <= 1'b0;
      end else if (aclr || load_ff) begin
         oe_neg_ff <= ini;
      end else if (fall_out && ctl[`CTL_CEO]) begin
         oe_neg_ff <= ctl[`CTL_SCLR] ? ini : oe_ff;
      end
   end

   // Pin drive: clock-level mux for DDR, delayed enable for bidirectional DDR
   always_ff @(posedge mclk) begin
      if (rst) begin
         pin_o_ff <= 1'b0;
         pin_oe_ff <= 1'b0;
      end else begin
         pin_o_ff <= (ddr_out && !ctl[`CTL_CKO]) ? out_b_ff : out_a_ff;
         unique case (ctrl_ff.mode)
            MODE_DDR_IN: pin_oe_ff <= 1'b0;
            MODE_DDR_BIDIR: pin_oe_ff <= oe_ff & oe_neg_ff;
            MODE_SDR, MODE_DDR_OUT: pin_oe_ff <= oe_ff;
         endcase
      end
   end

   assign pin_o = pin_o_ff;
   assign pin_oe = pin_oe_ff;
   assign rx_hi = rx_hi_ff;
   assign rx_lo = rx_lo_ff;
   assign rx_route = rx_route_ff;

   // ************************************************
   // AXI4-Lite slave
   // ************************************************
   assign we = aw_hold_ff && w_hold_ff && !bvalid_ff;

   // Write address and data taken in either order, response after both
   always_ff @(posedge mclk) begin
      if (rst) begin
         awready_ff <= 1'b0;
         wready_ff <= 1'b0;
         aw_hold_ff <= 1'b0;
         w_hold_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         bresp_ff <= `RESP_OKAY;
         awaddr_ff <= '0;
         wdata_ff <= '0;
         wstrb_ff <= '0;
      end else begin
         if (s_axi_awvalid && awready_ff) begin
            awready_ff <= 1'b0;
            aw_hold_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
         end else if (!aw_hold_ff && !bvalid_ff) begin
            awready_ff <= 1'b1;
         end
         if (s_axi_wvalid && wready_ff) begin
            wready_ff <= 1'b0;
            w_hold_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end else if (!w_hold_ff && !bvalid_ff) begin
            wready_ff <= 1'b1;
         end
         if (we) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_ff <= (awaddr_ff > `ADDR_STAT || awaddr_ff[1:0] != 2'h0) ? `RESP_SLVERR : `RESP_OKAY;
         end else if (bvalid_ff && s_axi_bready) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   // Configuration registers; the load bit pulses for one cycle
   always_ff @(posedge mclk) begin
      if (rst) begin
         ctrl_ff <= ctrl_s'(`CTRL_RST);
         sel0_ff <= `SEL0_RST;
         sel1_ff <= `SEL1_RST;
         load_ff <= 1'b0;
      end else begin
         load_ff <= 1'b0;
         if (we) begin
            unique case (awaddr_ff)
               `ADDR_CTRL: begin
                  ctrl_ff <= ctrl_s'(merge(ctrl_ff, wdata_ff, wstrb_ff) & `CTRL_MASK);
                  load_ff <= wstrb_ff[0] & wdata_ff[`CTRL_LOAD_BIT];
               end
               `ADDR_SEL0: sel0_ff <= merge(sel0_ff, wdata_ff, wstrb_ff) & `SEL0_MASK;
               `ADDR_SEL1: sel1_ff <= merge(sel1_ff, wdata_ff, wstrb_ff) & `SEL1_MASK;
               default: load_ff <= 1'b0;
            endcase
         end
      end
   end

   // Status word of live element state
   always_comb begin
      stat = '0;
      stat.pin_lvl = pin_v;
      stat.in_pos = in_pos_ff;
      stat.in_neg = in_neg_ff;
      stat.lat = lat_ff;
      stat.out_a = out_a_ff;
      stat.out_b = out_b_ff;
      stat.oe = oe_ff;
      stat.oe_neg = oe_neg_ff;
      stat.pin_o = pin_o_ff;
      stat.pin_oe = pin_oe_ff;
      stat.rx_hi = rx_hi_ff;
      stat.rx_lo = rx_lo_ff;
      stat.aclr_on = aclr;
   end

   // Read channel: one cycle from address to data
   always_ff @(posedge mclk) begin
      if (rst) begin
         arready_ff <= 1'b0;
         rvalid_ff <= 1'b0;
         rdata_ff <= '0;
         rresp_ff <= `RESP_OKAY;
      end else if (s_axi_arvalid && arready_ff) begin
         arready_ff <= 1'b0;
         rvalid_ff <= 1'b1;
         rresp_ff <= `RESP_OKAY;
         unique case (s_axi_araddr)
            `ADDR_CTRL: rdata_ff <= ctrl_ff;
            `ADDR_SEL0: rdata_ff <= sel0_ff;
            `ADDR_SEL1: rdata_ff <= sel1_ff;
            `ADDR_STAT: rdata_ff <= stat;
            default: begin
               rdata_ff <= '0;
               rresp_ff <= `RESP_SLVERR;
            end
         endcase
      end else if (rvalid_ff && s_axi_rready) begin
         rvalid_ff <= 1'b0;
      end else if (!rvalid_ff) begin
         arready_ff <= 1'b1;
      end
   end

   assign s_axi_awready = awready_ff;
   assign s_axi_wready = wready_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;

   // ************************************************
   // Assertions
   // ************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   AST_ACLR_WINS: assert property (aclr |=> (out_a_ff == $past(ini)) && (in_pos_ff == $past(ini))
      && (oe_neg_ff == $past(ini))) else $error("clear or preset did not force registers");
   AST_CEO_HOLD: assert property ((!aclr && !load_ff && !(rise_out && ctl[`CTL_CEO])) |=>
      $stable(out_a_ff) && $stable(out_b_ff) && $stable(oe_ff)) else $error("output regs moved");
   AST_IN_RISE: assert property ((rise_in && ctl[`CTL_CEI] && !ctl[`CTL_SCLR] && !aclr && !load_ff) |=>
      in_pos_ff == $past(pin_v)) else $error("rising input capture wrong");
   AST_NEG_ONLY_FALL: assert property ((!fall_out && !aclr && !load_ff) |=> $stable(oe_neg_ff))
      else $error("falling enable reg moved off edge");
   AST_SCLR_OUT: assert property ((rise_out && ctl[`CTL_CEO] && ctl[`CTL_SCLR] && !aclr && !load_ff) |=>
      (out_a_ff == $past(ini)) && (oe_ff == $past(ini))) else $error("sync reset ignored");
   AST_LATCH_HOLD: assert property ((!ctl[`CTL_CKI] && !aclr && !load_ff) |=> $stable(lat_ff))
      else $error("latch changed while clock low");
   AST_OE_POL: assert property ((rise_out && ctl[`CTL_CEO] && !ctl[`CTL_SCLR] && !aclr && !load_ff
      ##1 !aclr && !load_ff && ctrl_ff.mode == MODE_SDR) |=> pin_oe_ff == $past(oe_src, 2))
      else $error("tristate polarity wrong");
   AST_DDR_HIGH: assert property ((rise_out && ctl[`CTL_CEO] && !ctl[`CTL_SCLR] && !aclr && !load_ff
      ##1 !aclr && !load_ff && ddr_out && ctl[`CTL_CKO]) |=> pin_o_ff == $past(din_a, 2))
      else $error("first bit not on pin in clock high");
   AST_BRESP: assert property ((s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready) |->
      ##2 s_axi_bvalid) else $error("write response late");

   COV_DDR_IN: cover property (ddr_in && fall_d_ff && ctrl_ff.dq_pin);
   COV_DDR_OUT: cover property (ddr_out && rise_out && ctl[`CTL_CEO] ##[1:20] fall_out);
   COV_BIDIR_OE: cover property (ctrl_ff.mode == MODE_DDR_BIDIR && $rose(pin_oe_ff));
   COV_ACLR: cover property (aclr && rise_out && ctl[`CTL_CEO]);

endmodule : io_element_ddr

// ### core/ioe_regs.svh
// Register offsets, field positions and reset values of the I/O element
`ifndef IO_ELEMENT_REGS_SVH
`define IO_ELEMENT_REGS_SVH
`define AXI_AW 8
`define ADDR_CTRL 8'h00
`define ADDR_SEL0 8'h04
`define ADDR_SEL1 8'h08
`define ADDR_STAT 8'h0C
`define CTRL_RST 32'h0000_0000
`define CTRL_MASK 32'h03FF_073F
`define CTRL_LOAD_BIT 6
`define SEL0_RST 32'h000F_7FFF
`define SEL0_MASK 32'h000F_FFFF
`define SEL1_RST 32'h0000_001E
`define SEL1_MASK 32'h0000_7FFF
`define SEL_W 5
`define SEL_PER_REG 4
`define N_CTL 7
`define CTL_OE 0
`define CTL_CEI 1
`define CTL_CEO 2
`define CTL_ACLR 3
`define CTL_SCLR 4
`define CTL_CKI 5
`define CTL_CKO 6
`define INV_DA 7
`define INV_DB 8
`define INV_PIN 9
`define N_IOCLK 8
`define BLK_N 4
`define COL_N 6
`define EXT_W 10
`define SRC_DQS 29
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ### core/ioe_pkg.sv
// Types shared by the I/O element design
package io_element_pkg;
`include "ioe_regs.svh"
   typedef enum logic [1:0] {
      MODE_SDR = 2'h0,
      MODE_DDR_IN = 2'h1,
      MODE_DDR_OUT = 2'h2,
      MODE_DDR_BIDIR = 2'h3
   } mode_e;
   typedef logic [`SEL_W-1:0] sel_t;
   typedef struct packed {
      logic [`BLK_N-1:0] oe;
      logic [`BLK_N-1:0] ce;
      logic [`BLK_N-1:0] clk;
      logic [`BLK_N-1:0] clr;
   } blk_ctrl_s;
   typedef struct packed {
      logic [`COL_N-1:0] data_a;
      logic [`COL_N-1:0] data_b;
      logic [`COL_N-1:0] oe;
      logic [`COL_N-1:0] ce_in;
      logic [`COL_N-1:0] ce_out;
      logic [`COL_N-1:0] clk;
      logic [`COL_N-1:0] clr;
   } col_lines_s;
   typedef struct packed {
      logic [5:0] rsv_hi;
      logic [9:0] inv;
      logic [4:0] rsv_mid;
      logic [2:0] lane;
      logic rsv_lo;
      logic load;
      logic dqs_pin;
      logic dq_pin;
      logic preset;
      logic oe_low;
      mode_e mode;
   } ctrl_s;
   typedef struct packed {
      logic [18:0] rsv;
      logic pin_lvl;
      logic in_pos;
      logic in_neg;
      logic lat;
      logic out_a;
      logic out_b;
      logic oe;
      logic oe_neg;
      logic pin_o;
      logic pin_oe;
      logic rx_hi;
      logic rx_lo;
      logic aclr_on;
   } stat_s;
endpackage : io_element_pkg

// ### testbench/pin_partner.sv
// Far-side pin device that shares the element's single data pin
`timescale 1ns/1ps
module pin_partner (
   input wire logic pin_o,
   input wire logic pin_oe,
   input wire logic tx_bit,
   output logic pin_i
);
   // Wire level: the element wins while it drives, else this device sends tx_bit
   assign pin_i = pin_oe ? pin_o : tx_bit;
endmodule : pin_partner

// ### testbench/io_element_ddr_registers_bench.sv
// Self-checking bench for the I/O element with expected values worked out inline
`timescale 1ns/1ps
`include "ioe_regs.svh"
module io_element_ddr_registers_bench import io_element_pkg::*;;
   logic mclk, rst, dqs_pin_in, tx_bit, pin_i, pin_o, pin_oe, rx_hi, rx_lo, rx_route;
   logic [7:0] io_clk, awaddr, araddr;
   logic [31:0] wdata, rdata, r;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   blk_ctrl_s blk;
   col_lines_s col;
   int n_errors, cmp_count, m, i, oe_n;
   integer seed = 32'hBE91A5CE;

   io_element_ddr DUT (.mclk(mclk), .rst(rst), .io_clk(io_clk), .blk(blk), .col(col), .dqs_pin_in(dqs_pin_in),
      .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .rx_hi(rx_hi), .rx_lo(rx_lo), .rx_route(rx_route),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready));
   pin_partner far_end (.pin_o(pin_o), .pin_oe(pin_oe), .tx_bit(tx_bit), .pin_i(pin_i));

   // Clock of 100 ns period
   initial begin
      mclk = 1'h0;
      forever #50 mclk = ~mclk;
   end

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : test_done

   // Register write: address and data offered together, each dropped when taken
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic [2:0] hs;
      hs = 3'h0;
      @(posedge mclk);
      awaddr <= a;
      wdata <= d;
      {awvalid, wvalid, bready} <= 3'h7;
      while (!hs[0]) begin
         @(negedge mclk);
         hs = {awvalid & awready, wvalid & wready, bvalid};
         if (hs[0]) chk("bresp", er, bresp);
         @(posedge mclk);
         if (hs[2]) awvalid <= 1'h0;
         if (hs[1]) wvalid <= 1'h0;
      end
      bready <= 1'h0;
   endtask : axw

   // Register read with data and response compared at the handshake
   task automatic axr(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      logic [1:0] hs;
      hs = 2'h0;
      @(posedge mclk);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      while (!hs[0]) begin
         @(negedge mclk);
         hs = {arvalid & arready, rvalid};
         if (hs[0]) chk("rdata", exp, rdata);
         if (hs[0]) chk("rresp", er, rresp);
         @(posedge mclk);
         if (hs[1]) arvalid <= 1'h0;
      end
      rready <= 1'h0;
   endtask : axr

   // One element clock phase of 13 cycles; far-side data moves mid-phase
   task automatic half(input logic ck, input logic d);
      @(posedge mclk);
      blk.clk[1:0] <= {ck, ck};
      repeat (4) @(posedge mclk);
      tx_bit <= d;
      {io_clk, dqs_pin_in} <= 9'($random(seed));
      repeat (8) @(posedge mclk);
      @(negedge mclk);
   endtask : half

   // Present lane-0 data, then a low phase and a high phase
   task automatic cyc(input logic [3:0] v);
      @(posedge mclk);
      col.data_a[0] <= v[0];
      col.data_b[0] <= v[1];
      half(1'h0, v[2]);
      half(1'h1, v[3]);
   endtask : cyc

   // Hang guard
   initial begin
      repeat (6000) @(posedge mclk);
      n_errors++;
      test_done;
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      rst = 1'h1;
      {awvalid, wvalid, bready, arvalid, rready, tx_bit, dqs_pin_in} = 7'h00;
      {awaddr, araddr, wdata, io_clk} = '0;
      wstrb = 4'hF;
      blk = {8'($random(seed)), 8'h00};
      col = 42'({$random(seed), $random(seed)});
      repeat (20) @(posedge mclk);
      rst <= 1'h0;
      repeat (2) @(posedge mclk);
      chk("pins after reset", 2'h0, {pin_o, pin_oe});
      axr(`ADDR_CTRL, `CTRL_RST, `RESP_OKAY);
      axr(`ADDR_SEL0, `SEL0_RST, `RESP_OKAY);
      axr(`ADDR_SEL1, `SEL1_RST, `RESP_OKAY);
      axr(8'h10, 32'h0, `RESP_SLVERR);
      axr(8'h05, 32'h0, `RESP_SLVERR);
      axw(8'h10, 32'hFFFF_FFFF, `RESP_SLVERR);
      axw(`ADDR_STAT, 32'hFFFF_FFFF, `RESP_OKAY);
      axw(`ADDR_SEL0, 32'hFFFA_7FFF, `RESP_OKAY);
      axw(`ADDR_SEL1, 32'h0000_4235, `RESP_OKAY);
      axr(`ADDR_SEL0, 32'h000A_7FFF, `RESP_OKAY);
      axr(`ADDR_SEL1, 32'h0000_4235, `RESP_OKAY);
      $display("test registers done");
      // Every mode with random data, compared after each high phase and the low phase that follows
      for (m = 0; m < 4; m++) begin
         axw(`ADDR_CTRL, 32'h40 | m | ((m == 1) ? 32'h10 : 32'h0), `RESP_OKAY);
         oe_n = 0;
         for (i = 0; i < 6; i++) begin
            r = $random(seed);
            cyc(r[3:0]);
            chk("pin_oe high", (m != 1) & (oe_n | m != 3), pin_oe);
            if (m != 1) chk("pin_o high", r[0], pin_o);
            if (m == 0) chk("rx_route", r[0], rx_route);
            half(1'h0, r[4]);
            oe_n = 1;
            chk("pin_oe low", m != 1, pin_oe);
            if (m != 1) chk("pin_o low", (m == 0) ? r[0] : r[1], pin_o);
            if (m == 1) chk("rx pair", {r[2], r[3]}, {rx_hi, rx_lo});
         end
         $display("test mode %0d done", m);
      end
      // Active-low enable and inverted data input
      axw(`ADDR_CTRL, 32'h0080_0044, `RESP_OKAY);
      cyc(4'h1);
      chk("pin_o inverted", 1'h0, pin_o);
      chk("pin_oe active low", 1'h0, pin_oe);
      $display("test invert done");
      // Clear, then preset, override the clock
      axw(`ADDR_CTRL, 32'h40, `RESP_OKAY);
      blk.clr[0] <= 1'h1;
      cyc(4'h1);
      chk("pin_o cleared", 1'h0, pin_o);
      axr(`ADDR_STAT, 32'h1, `RESP_OKAY);
      axw(`ADDR_CTRL, 32'h48, `RESP_OKAY);
      cyc(4'h0);
      chk("pins preset", 2'h3, {pin_o, pin_oe});
      blk.clr[0] <= 1'h0;
      // Synchronous reset at a clock edge
      axw(`ADDR_CTRL, 32'h40, `RESP_OKAY);
      blk.clr[1] <= 1'h1;
      cyc(4'h1);
      chk("pin_o sync reset", 1'h0, pin_o);
      blk.clr[1] <= 1'h0;
      half(1'h0, 1'h0);
      cyc(4'h1);
      chk("pin_o after sync reset", 1'h1, pin_o);
      $display("test clear done");
      test_done;
   end
endmodule : io_element_ddr_registers_bench
